//--- odrl_pkg.sv
// package: register map, field layout and timing for the output route and level bank
package odrl_pkg;
  localparam int ODRL_ADDR_W = 12;
  // printed offsets are not multiples of four: indices, byte address = 4 * index
  localparam logic [7:0] ODRL_IDX_LCOM_LEVEL = 8'h3A;
  localparam logic [7:0] ODRL_IDX_RSVD_59 = 8'h3B;
  localparam logic [7:0] ODRL_IDX_LPGA_RHP = 8'h3C;
  localparam logic [7:0] ODRL_IDX_LDAC_RHP = 8'h3D;
  localparam logic [7:0] ODRL_IDX_RSVD_62 = 8'h3E;
  localparam logic [7:0] ODRL_IDX_RPGA_RHP = 8'h3F;
  localparam logic [7:0] ODRL_IDX_RDAC_RHP = 8'h40;
  localparam logic [7:0] ODRL_IDX_RHP_LEVEL = 8'h41;
  localparam logic [7:0] ODRL_IDX_RSVD_66 = 8'h42;
  localparam logic [7:0] ODRL_IDX_LPGA_RCOM = 8'h43;
  localparam logic [7:0] ODRL_IDX_FIRST = ODRL_IDX_LCOM_LEVEL;
  localparam int ODRL_NREG = 10;

  // level register layout
  localparam int ODRL_LVL_MSB = 7;
  localparam int ODRL_LVL_LSB = 4;
  localparam int ODRL_MUTE_BIT = 3;
  localparam int ODRL_PDDRV_BIT = 2;
  localparam int ODRL_PEND_BIT = 1;
  localparam int ODRL_PWR_BIT = 0;
  localparam logic [7:0] ODRL_LEVEL_RST = 8'h06;
  localparam logic [7:0] ODRL_LEVEL_WMASK = 8'hFD;
  // route register layout
  localparam int ODRL_EN_BIT = 7;
  localparam int ODRL_VOL_MSB = 6;
  localparam logic [7:0] ODRL_ROUTE_RST = 8'h00;
  localparam logic [7:0] ODRL_RSVD_RST = 8'h00;

  // gain ramp settle time
  localparam int ODRL_CLK_HZ = 40_000_000;
  localparam int ODRL_SETTLE_US = 10;
  localparam int ODRL_SETTLE_CYC = (ODRL_SETTLE_US * (ODRL_CLK_HZ / 1_000_000));

  typedef struct packed {
    logic [3:0] level;
    logic unmute;
    logic pd_hiz;
    logic gain_pending;
    logic power_up;
  } odrl_drv_s;

  typedef struct packed {
    logic enable;
    logic [6:0] volume;
  } odrl_route_s;
endpackage : odrl_pkg

//--- odrl_regs.sv
// module: APB register bank for output routing and driver level control
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - level field bits 7-4, 0-9 dB, reset 0
// - bit 3 unmutes, resets muted
// - bit 2 selects high-impedance power-down, resets 1
// - bit 1 read-only gain pending status, resets 1
// - bit 0 fully powers driver, resets 0
// - route bit 7 connects source, resets 0
// - route bits 6-0 volume code, resets 0
// - right headphone routes at 60, 61, 63, 64
// - index 67 routes left gain amp to right common
// - level registers at 58 and 65
module odrl_regs
  import odrl_pkg::*;
#(
  parameter int SETTLE_CYC = ODRL_SETTLE_CYC
) (
  input wire logic clock_in, // 40 MHz clock
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [ODRL_ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic pready, // apb ready, always high
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error on unmapped address
  output odrl_drv_s left_common_driver_out, // left common driver settings
  output odrl_drv_s right_headphone_driver_out, // right headphone driver settings
  output odrl_route_s left_input_gain_amp_to_rhp_out, // route 60
  output odrl_route_s left_converter_out_to_rhp_out, // route 61
  output odrl_route_s right_input_gain_amp_to_rhp_out, // route 63
  output odrl_route_s right_converter_out_to_rhp_out, // route 64
  output odrl_route_s left_input_gain_amp_to_rcom_out, // route 67
  output logic right_common_gain_pending_out // right common driver gain change pending
);
  localparam int CW = $clog2(SETTLE_CYC + 1);

  typedef struct packed {
    logic [ODRL_NREG-1:0][7:0] regs;
    logic [2:0][CW-1:0] cnt;
    logic [2:0] pend;
    logic [31:0] rdata;
  } odrl_state_s;

  odrl_state_s s_q, s_d;

  logic [7:0] idx;
  logic [3:0] slot;
  logic mapped, wr_en, rd_en;
  logic [2:0] touch;

  always_comb begin
    idx = paddr[ODRL_ADDR_W-1:2] < 10'h100 ? 8'(paddr[ODRL_ADDR_W-1:2]) : 8'hFF;
    slot = 4'(idx - ODRL_IDX_FIRST);
    mapped = (idx >= ODRL_IDX_FIRST) && (idx <= ODRL_IDX_LPGA_RCOM) && (paddr[1:0] == 2'b00);
    wr_en = psel && penable && pwrite && mapped && pstrb[0];
    // read word is captured in the setup cycle so it stands, registered, in the access cycle
    rd_en = psel && !penable && !pwrite;
    touch = 3'b000;
    s_d = s_q;
    if (wr_en) begin
      if (idx == ODRL_IDX_LCOM_LEVEL || idx == ODRL_IDX_RHP_LEVEL) begin
        // status bit is read-only; keep its stored copy
        s_d.regs[slot] = (pwdata[7:0] & ODRL_LEVEL_WMASK) | (s_q.regs[slot] & ~ODRL_LEVEL_WMASK);
      end else begin
        s_d.regs[slot] = pwdata[7:0];
      end
      // pending: level or route feeding that driver was written
      if (idx == ODRL_IDX_LCOM_LEVEL) touch[0] = 1'b1;
      if (idx == ODRL_IDX_RHP_LEVEL || idx == ODRL_IDX_LPGA_RHP || idx == ODRL_IDX_LDAC_RHP ||
          idx == ODRL_IDX_RPGA_RHP || idx == ODRL_IDX_RDAC_RHP) touch[1] = 1'b1;
      if (idx == ODRL_IDX_LPGA_RCOM) touch[2] = 1'b1;
    end
    for (int i = 0; i < 3; i++) begin
      if (touch[i]) begin
        s_d.pend[i] = 1'b1;
        s_d.cnt[i] = CW'(SETTLE_CYC);
      end else if (s_q.pend[i]) begin
        if (s_q.cnt[i] <= CW'(1)) begin
          s_d.pend[i] = 1'b0;
          s_d.cnt[i] = '0;
        end else begin
          s_d.cnt[i] = s_q.cnt[i] - CW'(1);
        end
      end
    end
    if (rd_en) begin
      s_d.rdata = '0;
      if (mapped) begin
        s_d.rdata[7:0] = s_q.regs[slot];
        if (idx == ODRL_IDX_LCOM_LEVEL) s_d.rdata[ODRL_PEND_BIT] = s_q.pend[0];
        if (idx == ODRL_IDX_RHP_LEVEL) s_d.rdata[ODRL_PEND_BIT] = s_q.pend[1];
      end
    end
    if (!rst_n_in) begin
      for (int i = 0; i < ODRL_NREG; i++) s_d.regs[i] = ODRL_ROUTE_RST;
      s_d.regs[0] = ODRL_LEVEL_RST;
      s_d.regs[7] = ODRL_LEVEL_RST;
      s_d.pend = 3'b111;
      s_d.cnt = '0;
      s_d.rdata = '0;
      s_d.cnt[0] = CW'(SETTLE_CYC);
      s_d.cnt[1] = CW'(SETTLE_CYC);
      s_d.cnt[2] = CW'(SETTLE_CYC);
    end
  end

  always_ff @(posedge clock_in) begin
    s_q <= s_d;
  end

  // read data is registered at the setup edge and stands through the access phase
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = s_q.rdata;

  always_comb begin
    left_common_driver_out = odrl_drv_s'(s_q.regs[0]);
    left_common_driver_out.gain_pending = s_q.pend[0];
    right_headphone_driver_out = odrl_drv_s'(s_q.regs[7]);
    right_headphone_driver_out.gain_pending = s_q.pend[1];
  end
  assign left_input_gain_amp_to_rhp_out = odrl_route_s'(s_q.regs[2]);
  assign left_converter_out_to_rhp_out = odrl_route_s'(s_q.regs[3]);
  assign right_input_gain_amp_to_rhp_out = odrl_route_s'(s_q.regs[5]);
  assign right_converter_out_to_rhp_out = odrl_route_s'(s_q.regs[6]);
  assign left_input_gain_amp_to_rcom_out = odrl_route_s'(s_q.regs[9]);
  assign right_common_gain_pending_out = s_q.pend[2];
endmodule : odrl_regs
`default_nettype wire

//--- odrl_regs_checker.sv
// checker: port properties of the output route and level register bank
`timescale 1ns/1ps
`default_nettype none
module odrl_regs_checker
  import odrl_pkg::*;
(
  input wire logic clock_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // direction
  input wire logic [ODRL_ADDR_W-1:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [3:0] pstrb, // strobes
  input wire logic pslverr, // error
  input wire odrl_drv_s left_common_driver_out, // left common
  input wire odrl_drv_s right_headphone_driver_out, // right headphone
  input wire odrl_route_s left_input_gain_amp_to_rcom_out, // route 67
  input wire logic right_common_gain_pending_out // right common pending
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  wire logic wr = psel && penable && pwrite && pstrb[0];
  a_lcom_fields: assert property (wr && paddr == 12'h0E8 |=>
    (left_common_driver_out & 8'hFD) == ($past(pwdata[7:0]) & 8'hFD)) else $error("lcom bad");
  a_rhp_fields: assert property (wr && paddr == 12'h104 |=>
    (right_headphone_driver_out & 8'hFD) == ($past(pwdata[7:0]) & 8'hFD)) else $error("rhp bad");
  a_rcom_route: assert property (wr && paddr == 12'h10C |=>
    left_input_gain_amp_to_rcom_out == $past(pwdata[7:0])) else $error("route bad");
  a_lcom_pend: assert property (wr && paddr == 12'h0E8 |=>
    left_common_driver_out.gain_pending) else $error("lcom pending low");
  a_rcom_pend: assert property (wr && paddr == 12'h10C |=>
    right_common_gain_pending_out) else $error("rcom pending low");
  a_rst_pend: assert property ($rose(rst_n_in) |->
    left_common_driver_out.gain_pending && right_headphone_driver_out.gain_pending)
    else $error("pending low after reset");
  a_lvl_hold: assert property (!wr |=> $stable(left_common_driver_out.level))
    else $error("level moved");
  a_bad_addr: assert property (psel && penable && paddr == 12'h0E4 |-> pslverr)
    else $error("no error");
  a_rsvd_ok: assert property (psel && penable && paddr == 12'h0EC |-> !pslverr)
    else $error("reserved refused");
endmodule : odrl_regs_checker
bind odrl_regs odrl_regs_checker u_chk (.clock_in, .rst_n_in, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pslverr, .left_common_driver_out, .right_headphone_driver_out,
  .left_input_gain_amp_to_rcom_out, .right_common_gain_pending_out);
`default_nettype wire

//--- odrl_regs_test.sv
// testbench: random and corner register traffic on the route and level bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module odrl_regs_test
  import odrl_pkg::*;
;
  logic clock_in = 0, rst_n_in = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rdata;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] d;
  wire logic pready, pslverr, rcom_pend;
  wire logic [31:0] prdata;
  wire odrl_drv_s lcom;
  wire odrl_route_s rcom;
  int num_errors = 0, comparisons = 0, cycles = 0, seed = 32'h2bd9, i, n;
  always #12.5 clock_in = ~clock_in;
  odrl_regs #(.SETTLE_CYC(8)) u_dut (.clock_in, .rst_n_in, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .left_common_driver_out(lcom),
    .right_headphone_driver_out(), .left_input_gain_amp_to_rhp_out(),
    .left_converter_out_to_rhp_out(), .right_input_gain_amp_to_rhp_out(),
    .right_converter_out_to_rhp_out(), .left_input_gain_amp_to_rcom_out(rcom),
    .right_common_gain_pending_out(rcom_pend));
  function automatic logic [11:0] adr(int k);
    return 12'(4 * (int'(ODRL_IDX_FIRST) + k));
  endfunction : adr
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock_in) penable <= 1;
    do @(posedge clock_in); while (pready !== 1'b1);
    err = pslverr;
    rdata = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge clock_in);
  endtask : xfer
  task end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test;
    end
  end
  initial begin
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1;
    @(posedge clock_in);
    `CHK("lcom", 8'h06, lcom)
    for (i = 0; i < 10; i++) begin
      xfer(0, adr(i), 0);
      `CHK("rst", {24'h0, i == 0 ? 8'h06 : i == 7 ? 8'h04 : 8'h00}, rdata)
    end
    for (n = 0; n < 40; n++) begin
      i = $unsigned($random(seed)) % 10;
      if (i == 1 || i == 4 || i == 8) i = i + 1;
      d = 8'($random(seed));
      if (i == 0 || i == 7) d[7:4] = d[7:4] % 10;
      xfer(1, adr(i), {24'($random(seed)), d});
      `CHK("werr", 1'b0, err)
      xfer(0, adr(i), 0);
      `CHK("rdbk", {24'h0, (i == 0 || i == 7) ? (d & 8'hFD) | 8'h02 : d}, rdata)
    end
    repeat (12) @(posedge clock_in);
    xfer(0, 12'h0E8, 0);
    `CHK("settled", 1'b0, rdata[1])
    xfer(1, 12'h10C, 32'h85);
    `CHK("route", 8'h85, rcom)
    `CHK("rpend", 1'b1, rcom_pend)
    xfer(0, 12'h0E4, 0);
    `CHK("slverr", 1'b1, err)
    end_of_test;
  end
endmodule : odrl_regs_test
`default_nettype wire
